// >>> src/uep0_map.vh
`ifndef UEP0_MAP_VH
`define UEP0_MAP_VH
// register word offsets on the plain register port
`define UEP0_ADDR_CTRL       4'h0
`define UEP0_ADDR_STATUS     4'h1
`define UEP0_ADDR_PENDING    4'h2
`define UEP0_ADDR_EP0CS      4'h3
`define UEP0_ADDR_EP0DATA    4'h4
`define UEP0_ADDR_EP0COUNT   4'h5
`define UEP0_ADDR_PENDMASK   4'h6
// control register bits
`define UEP0_CTRL_RESUME_INT_MASK_BIT  2
`define UEP0_CTRL_SUSPEND_INT_MASK_BIT  6
`define UEP0_CTRL_RESET      8'h40
// status register bits
`define UEP0_STAT_SUS_BIT    3
`define UEP0_STAT_RES_BIT    4
`define UEP0_STAT_RST_BIT    5
// endpoint zero control and status bits
`define UEP0_CS_OPR_BIT      0
`define UEP0_CS_IPR_BIT      1
`define UEP0_CS_DE_BIT       4
`define UEP0_CS_SE_BIT       5
`define UEP0_CS_OCLR_BIT     6
`define UEP0_CS_SCLR_BIT     7
// pending register bits and reset value of the endpoint enables
`define UEP0_PEND_EP0_BIT    0
`define UEP0_PEND_EP1_BIT    1
`define UEP0_PEND_EP2_BIT    2
`define UEP0_PENDMASK_RESET  3'h1
// interrupt controller line of the device
`define UEP0_IRQ_LINE        13
// endpoint zero fifo geometry
`define UEP0_FIFO_DEPTH      8
`define UEP0_FIFO_AW         3
`define UEP0_COUNT_W         4
`endif

// >>> src/uep0_fifo.v
`timescale 1ns/1ps
`include "uep0_map.vh"
// endpoint zero byte fifo with a live byte count
module uep0_fifo (
  // clock and reset
  input  wire       i_mclk,
  input  wire       i_reset_n,
  // flush (bus reset)
  input  wire       i_flush,
  // write side
  input  wire       i_wr,
  input  wire [7:0] i_wdata,
  // read side
  input  wire       i_rd,
  output wire [7:0] o_rdata,
  // state
  output reg  [3:0] o_count
);
  reg [7:0] mem [0:`UEP0_FIFO_DEPTH-1];   // byte storage
  reg [2:0] wptr;                          // write pointer
  reg [2:0] rptr;                          // read pointer
  wire      do_wr;                         // accepted write
  wire      do_rd;                         // accepted read

  // refuse writes when full, reads when empty
  assign do_wr   = i_wr && (o_count != 4'h8);
  assign do_rd   = i_rd && (o_count != 4'h0);
  assign o_rdata = mem[rptr];

  // storage has no reset; the count guards stale bytes
  always @(posedge i_mclk) begin
    if (do_wr) begin
      mem[wptr] <= i_wdata;
    end
  end

  // pointers and count
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wptr    <= 3'h0;
      rptr    <= 3'h0;
      o_count <= 4'h0;
    end else if (i_flush) begin
      wptr    <= 3'h0;
      rptr    <= 3'h0;
      o_count <= 4'h0;
    end else begin
      if (do_wr) begin
        wptr <= wptr + 3'h1;
      end
      if (do_rd) begin
        rptr <= rptr + 3'h1;
      end
      if (do_wr && !do_rd) begin
        o_count <= o_count + 4'h1;
      end else if (do_rd && !do_wr) begin
        o_count <= o_count - 4'h1;
      end
    end
  end
endmodule

// >>> src/uep0_ctrl.v
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "uep0_map.vh"
// Summary of operation
// - pending request on irq bit thirteen
// - write one clears bus reset flag
// - suspend mask clear ignored during bus reset
// - mask blocks suspend; write one clears flag
// - resume mask one then zero resets suspend
// - write one clears resume flag
// - after reset only endpoint zero interrupt enabled
// - setup or out sets out ready, interrupts
// - byte count tracks fifo, one per access
// - write one to out clear drops out ready
// - in ready sends fifo on next in
// - nak in tokens until in ready
// - host ack clears in ready, interrupts
// - data end marks last transmit packet
// - zero length status out sets out ready
// - early status out sets flag and out ready
// - early clear; one write clears out, sets end
// - ack good setup and data, silent on error
module uep0_ctrl (
  // clock and reset
  input  wire       i_mclk,
  input  wire       i_reset_n,
  // register port
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // usb bus events from the serial engine
  input  wire       i_bus_reset,
  input  wire       i_suspend_det,
  input  wire       i_resume_det,
  input  wire       i_setup_tok,
  input  wire       i_out_tok,
  input  wire       i_in_tok,
  input  wire       i_rx_valid,
  input  wire [7:0] i_rx_byte,
  input  wire       i_pkt_good,
  input  wire       i_pkt_err,
  input  wire       i_host_ack,
  input  wire       i_tx_pop,
  // other endpoint events
  input  wire       i_ep1_event,
  input  wire       i_ep2_event,
  // handshake and transmit answers to the serial engine
  output wire       o_send_ack,
  output wire       o_send_nak,
  output wire       o_send_data,
  output wire [7:0] o_tx_byte,
  output wire       o_tx_last,
  // interrupt controller line
  output wire [31:0] o_irq_pending
);
  // transmit phase encodings
  localparam [1:0] PH_IDLE  = 2'h0;  // waiting for a setup
  localparam [1:0] PH_XMIT  = 2'h1;  // in data armed or sending
  localparam [1:0] PH_WAIT  = 2'h2;  // data stage ended, waiting status
  // control register reset image; one bit of it seeds the suspend mask
  localparam [7:0] CTRL_RESET_VAL = `UEP0_CTRL_RESET;
  reg  [1:0] phase;                  // tx_data_phase_state tracker
  reg  [1:0] next_phase;             // next tracker value

  reg        suspend_int_mask;       // blocks suspend events
  reg        resume_int_mask;        // resume mask, also suspend fsm clear
  reg        suspend_int_flag;       // sticky suspend event
  reg        resume_int_flag;        // sticky resume event
  reg        bus_reinit_flag;        // sticky bus reset event
  reg        suspended;              // internal suspend state
  reg        out_packet_ready;       // ep0 receive buffer full
  reg        in_packet_ready;        // ep0 transmit armed
  reg        data_end;               // last transmit packet marker
  reg        early_status_flag;      // premature status seen
  reg  [2:0] usb_pending_reg;        // per endpoint pending events
  reg  [2:0] ep_enable;              // per endpoint interrupt enables
  reg        rx_open;                // an out or setup packet is arriving

  wire [7:0] fifo_rdata;             // fifo head byte
  wire [3:0] ep0_byte_count;         // fifo occupancy
  wire       sw_wr_cs;               // write to ep0 control/status
  wire       sw_wr_st;               // write to status register
  wire       sw_rd_data;             // read of fifo data port
  wire       sw_wr_data;             // write of fifo data port
  wire       rx_done;                // good packet finished
  wire       status_out;             // good out packet end while armed, any length
  wire       ep0_event;              // ep0 interrupt cause
  wire       rx_accept;              // buffer can take a packet

  assign sw_wr_cs   = i_wr && (i_addr == `UEP0_ADDR_EP0CS);
  assign sw_wr_st   = i_wr && (i_addr == `UEP0_ADDR_STATUS);
  assign sw_rd_data = i_rd && (i_addr == `UEP0_ADDR_EP0DATA);
  assign sw_wr_data = i_wr && (i_addr == `UEP0_ADDR_EP0DATA);
  assign rx_accept  = !out_packet_ready;
  assign rx_done    = rx_open && i_pkt_good;
  // an out landing while data is armed and not finished is early status
  assign status_out = rx_done && (phase == PH_XMIT);

  assign o_send_ack  = rx_done;
  assign o_send_nak  = i_in_tok && !in_packet_ready;
  assign o_send_data = i_in_tok && in_packet_ready;
  assign o_tx_byte   = fifo_rdata;
  assign o_tx_last   = data_end;

  // ep0 fifo; serial engine fills it on receive and drains it on transmit
  uep0_fifo u_fifo (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_flush   (i_bus_reset),
    .i_wr      ((i_rx_valid && rx_open && !status_out) || sw_wr_data),
    .i_wdata   (sw_wr_data ? i_wdata : i_rx_byte),
    .i_rd      (sw_rd_data || i_tx_pop),
    .o_rdata   (fifo_rdata),
    .o_count   (ep0_byte_count)
  );

  // receive window: opens on setup/out token while out ready is clear, closes at packet end or bus reset
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_open <= 1'b0;
    end else if (i_bus_reset || i_pkt_good || i_pkt_err) begin
      rx_open <= 1'b0;
    end else if ((i_setup_tok || i_out_tok) && rx_accept) begin
      rx_open <= 1'b1;
    end
  end

  // transmit phase tracker
  always @* begin
    next_phase = phase;
    case (phase)
      PH_IDLE: begin
        if (in_packet_ready) begin
          next_phase = PH_XMIT;
        end
      end
      PH_XMIT: begin
        if (status_out) begin
          next_phase = PH_IDLE;
        end else if (i_host_ack && data_end) begin
          next_phase = PH_WAIT;
        end
      end
      PH_WAIT: begin
        if (rx_done) begin
          next_phase = PH_IDLE;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
    if (i_setup_tok) begin
      next_phase = PH_IDLE;
    end
  end

  // endpoint zero control and status bits
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase             <= PH_IDLE;
      out_packet_ready  <= 1'b0;
      in_packet_ready   <= 1'b0;
      data_end          <= 1'b0;
      early_status_flag <= 1'b0;
    end else if (i_bus_reset) begin
      phase             <= PH_IDLE;
      out_packet_ready  <= 1'b0;
      in_packet_ready   <= 1'b0;
      data_end          <= 1'b0;
      early_status_flag <= 1'b0;
    end else begin
      phase <= next_phase;
      if (rx_done) begin
        out_packet_ready <= 1'b1;
      end else if (sw_wr_cs && i_wdata[`UEP0_CS_OCLR_BIT]) begin
        out_packet_ready <= 1'b0;
      end
      if (status_out) begin
        early_status_flag <= 1'b1;
      end else if (sw_wr_cs && i_wdata[`UEP0_CS_SCLR_BIT]) begin
        early_status_flag <= 1'b0;
      end
      if (i_host_ack && in_packet_ready) begin
        in_packet_ready <= 1'b0;
      end else if (status_out) begin
        in_packet_ready <= 1'b0;
      end else if (sw_wr_cs && i_wdata[`UEP0_CS_IPR_BIT]) begin
        in_packet_ready <= 1'b1;
      end
      if (sw_wr_cs && i_wdata[`UEP0_CS_DE_BIT]) begin
        data_end <= 1'b1;
      end else if (rx_done && (phase != PH_XMIT)) begin
        data_end <= 1'b0;
      end else if (i_host_ack && in_packet_ready && data_end) begin
        data_end <= 1'b0;
      end
    end
  end

  assign ep0_event = rx_done || (i_host_ack && in_packet_ready);

  // suspend, resume and reset events with their masks
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      suspend_int_mask <= CTRL_RESET_VAL[`UEP0_CTRL_SUSPEND_INT_MASK_BIT];
      resume_int_mask  <= 1'b0;
      suspend_int_flag <= 1'b0;
      resume_int_flag  <= 1'b0;
      bus_reinit_flag  <= 1'b0;
      suspended        <= 1'b0;
    end else begin
      if (i_wr && (i_addr == `UEP0_ADDR_CTRL)) begin
        if (i_wdata[`UEP0_CTRL_SUSPEND_INT_MASK_BIT]) begin
          suspend_int_mask <= 1'b1;
        end else if (!i_bus_reset) begin
          suspend_int_mask <= 1'b0;
        end
        resume_int_mask <= i_wdata[`UEP0_CTRL_RESUME_INT_MASK_BIT];
      end
      // one then zero clears suspend fsm
      if (i_wr && (i_addr == `UEP0_ADDR_CTRL) && resume_int_mask
          && !i_wdata[`UEP0_CTRL_RESUME_INT_MASK_BIT]) begin
        suspended <= 1'b0;
      end else if (i_suspend_det) begin
        suspended <= 1'b1;
      end else if (i_resume_det || i_bus_reset) begin
        suspended <= 1'b0;
      end
      // set wins over a same cycle clear for every sticky flag
      // suspend flag clear
      if (i_suspend_det && !suspend_int_mask && !suspended) begin
        suspend_int_flag <= 1'b1;
      end else if (sw_wr_st && i_wdata[`UEP0_STAT_SUS_BIT]) begin
        suspend_int_flag <= 1'b0;
      end
      if (i_resume_det && suspended && !resume_int_mask) begin
        resume_int_flag <= 1'b1;
      end else if (sw_wr_st && i_wdata[`UEP0_STAT_RES_BIT]) begin
        resume_int_flag <= 1'b0;
      end
      if (i_bus_reset) begin
        bus_reinit_flag <= 1'b1;
      end else if (sw_wr_st && i_wdata[`UEP0_STAT_RST_BIT]) begin
        bus_reinit_flag <= 1'b0;
      end
    end
  end

  // endpoint pending bits and enables
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      usb_pending_reg <= 3'h0;
      ep_enable       <= `UEP0_PENDMASK_RESET;
    end else begin
      if (i_bus_reset) begin
        ep_enable <= `UEP0_PENDMASK_RESET;
      end else if (i_wr && (i_addr == `UEP0_ADDR_PENDMASK)) begin
        ep_enable <= i_wdata[2:0];
      end
      // set wins over write-one-to-clear
      usb_pending_reg <= (usb_pending_reg
                          & ~((i_wr && (i_addr == `UEP0_ADDR_PENDING)) ? i_wdata[2:0] : 3'h0))
                         | {i_ep2_event, i_ep1_event, ep0_event};
    end
  end

  assign o_irq_pending = {18'h0,
                          (|(usb_pending_reg & ep_enable)) | suspend_int_flag
                          | resume_int_flag | bus_reinit_flag,
                          13'h0};

  // read data, one cycle after the read strobe; unmapped reads zero
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `UEP0_ADDR_CTRL:     o_rdata <= {1'b0, suspend_int_mask, 3'h0,
                                         resume_int_mask, 2'h0};
        `UEP0_ADDR_STATUS:   o_rdata <= {2'h0, bus_reinit_flag, resume_int_flag,
                                         suspend_int_flag, 3'h0};
        `UEP0_ADDR_PENDING:  o_rdata <= {5'h0, usb_pending_reg};
        `UEP0_ADDR_EP0CS:    o_rdata <= {2'h0, early_status_flag, data_end, 2'h0,
                                         in_packet_ready, out_packet_ready};
        `UEP0_ADDR_EP0DATA:  o_rdata <= fifo_rdata;
        `UEP0_ADDR_EP0COUNT: o_rdata <= {4'h0, ep0_byte_count};
        `UEP0_ADDR_PENDMASK: o_rdata <= {5'h0, ep_enable};
        default:             o_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// >>> tb/uep0_props.sv
`timescale 1ns/1ps
// watches the ep0 handshake, transmit and irq outputs
module uep0_props (
  input wire        i_mclk,
  input wire        i_reset_n,
  input wire [3:0]  i_addr,
  input wire [7:0]  i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [7:0]  o_rdata,
  input wire        i_bus_reset,
  input wire        i_in_tok,
  input wire        i_pkt_good,
  input wire        i_pkt_err,
  input wire        i_host_ack,
  input wire        o_send_ack,
  input wire        o_send_nak,
  input wire        o_send_data,
  input wire        o_tx_last,
  input wire [31:0] o_irq_pending
);
  // one clock domain, so one default clock and reset
  default clocking dc @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  a_irq_line: assert property (
    {o_irq_pending[31:14], o_irq_pending[12:0]} == 31'h0)
    else $error("irq outside line 13");
  a_in_answer: assert property (
    i_in_tok |-> o_send_nak != o_send_data)
    else $error("in token not answered once");
  a_no_idle_send: assert property (
    !i_in_tok |-> !(o_send_nak || o_send_data))
    else $error("answer without in token");
  a_err_silent: assert property (
    i_pkt_err |-> !o_send_ack)
    else $error("ack on bad packet");
  a_ack_good: assert property (
    o_send_ack |-> i_pkt_good)
    else $error("ack without good end");
  a_rx_irq: assert property (
    o_send_ack |=> o_irq_pending[13])
    else $error("no irq after packet");
  a_ack_irq: assert property (
    i_host_ack |=> o_irq_pending[13])
    else $error("no irq after host ack");
  a_end_mark: assert property (
    i_wr && i_addr == 4'h3 && i_wdata[4] && !i_bus_reset |=> o_tx_last)
    else $error("data end not set");
  a_cs_fields: assert property (
    i_rd && i_addr == 4'h3 |=> o_rdata[7:6] == 2'h0 && o_rdata[3:2] == 2'h0)
    else $error("ep0 status stray bits");
  a_reset_clear: assert property (
    $rose(i_bus_reset) |=> !o_tx_last [*2])
    else $error("bus reset kept data end");
  c_setup: cover property (o_send_ack);
  c_nak: cover property (o_send_nak);
  c_in_done: cover property (i_host_ack ##1 o_irq_pending[13]);
endmodule
bind uep0_ctrl uep0_props props_u (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_bus_reset(i_bus_reset), .i_in_tok(i_in_tok), .i_pkt_good(i_pkt_good),
  .i_pkt_err(i_pkt_err), .i_host_ack(i_host_ack), .o_send_ack(o_send_ack),
  .o_send_nak(o_send_nak), .o_send_data(o_send_data), .o_tx_last(o_tx_last),
  .o_irq_pending(o_irq_pending)
);

// >>> tb/uep0_host.sv
`timescale 1ns/1ps
// host controller model on the serial engine side of ep0
module uep0_host (
  input  wire       i_mclk,
  input  wire       i_send_data,
  output reg        o_setup,
  output reg        o_out,
  output reg        o_in,
  output reg        o_rxv,
  output reg  [7:0] o_rxb,
  output reg        o_good,
  output reg        o_err,
  output reg        o_ack,
  output reg        o_pop,
  output reg        o_brst,
  output reg        o_susp,
  output reg        o_res
);
  reg [7:0] pay [0:7];  // payload of the next packet, filled by the bench
  initial {o_setup, o_out, o_in, o_rxv, o_rxb, o_good, o_err,
           o_ack, o_pop, o_brst, o_susp, o_res} = 19'h0;
  // token, n bytes, then a good or a damaged end
  // ep0 packets stay at eight bytes or fewer
  task pkt(input setup, input [3:0] n, input bad);
    integer i;
    begin
      @(posedge i_mclk);
      o_setup <= setup;
      o_out <= !setup;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge i_mclk);
        {o_setup, o_out} <= 2'h0;
        o_rxv <= 1'b1;
        o_rxb <= pay[i];
      end
      @(posedge i_mclk);
      {o_setup, o_out, o_rxv} <= 3'h0;
      // idle byte lane never keeps the last byte
      o_rxb <= ~o_rxb;
      o_good <= !bad;
      o_err <= bad;
      @(posedge i_mclk);
      {o_good, o_err} <= 2'h0;
    end
  endtask
  // in token; only when data comes back: pop n bytes, then ack
  task in_tx(input [3:0] n);
    integer i;
    begin
      @(posedge i_mclk);
      o_in <= 1'b1;
      @(posedge i_mclk);
      o_in <= 1'b0;
      if (i_send_data) begin
        for (i = 0; i < n; i = i + 1) begin
          o_pop <= 1'b1;
          @(posedge i_mclk);
        end
        o_pop <= 1'b0;
        o_ack <= 1'b1;
        @(posedge i_mclk);
        o_ack <= 1'b0;
      end
    end
  endtask
  // one-cycle suspend or resume detect
  task det(input res);
    begin
      @(posedge i_mclk);
      o_susp <= !res;
      o_res <= res;
      @(posedge i_mclk);
      {o_susp, o_res} <= 2'h0;
    end
  endtask
endmodule

// >>> tb/uep0_ctrl_bench.sv
`timescale 1ns/1ps
module uep0_ctrl_bench;
  reg         i_mclk;
  reg         i_reset_n;
  reg  [3:0]  i_addr;
  reg  [7:0]  i_wdata;
  reg         i_wr;
  reg         i_rd;
  wire [7:0]  o_rdata;
  wire        stok, otok, itok, rxv, good, err, hack, pop, brst, susp, resm, sdat;
  wire [7:0]  rxb;
  wire [7:0]  txb;
  wire [31:0] irq;       // interrupt controller pending lines
  reg         ev1;       // endpoint one event pulse
  reg  [15:0] expq [$];  // {mask, value} of each result still due
  reg         rd_d;      // read data due at this edge
  reg  [31:0] rng;
  reg  [7:0]  tb [0:2];
  integer     num_errors, total_checks, cyc, i;
  uep0_ctrl dut_u (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_bus_reset(brst), .i_suspend_det(susp), .i_resume_det(resm),
    .i_setup_tok(stok), .i_out_tok(otok), .i_in_tok(itok),
    .i_rx_valid(rxv), .i_rx_byte(rxb), .i_pkt_good(good),
    .i_pkt_err(err), .i_host_ack(hack), .i_tx_pop(pop),
    .i_ep1_event(ev1), .i_ep2_event(1'b0),
    .o_send_ack(), .o_send_nak(), .o_send_data(sdat),
    .o_tx_byte(txb), .o_tx_last(), .o_irq_pending(irq)
  );
  uep0_host host_u (
    .i_mclk(i_mclk), .i_send_data(sdat), .o_setup(stok), .o_out(otok),
    .o_in(itok), .o_rxv(rxv), .o_rxb(rxb), .o_good(good), .o_err(err),
    .o_ack(hack), .o_pop(pop), .o_brst(brst), .o_susp(susp), .o_res(resm)
  );
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // one write cycle; a gap edge follows so strobes never merge
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
    end
  endtask
  // one read cycle; note {mask, value} for the watcher
  task rd(input [3:0] a, input [15:0] me);
    begin
      expq.push_back(me);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
    end
  endtask
  task fill;
    for (i = 0; i < 8; i = i + 1) begin
      rng = xs(rng);
      host_u.pay[i] = rng[7:0];
    end
  endtask
  task cmp(input [7:0] got);
    reg [15:0] n;
    begin
      n = expq.pop_front();
      total_checks = total_checks + 1;
      if ((got & n[15:8]) !== n[7:0]) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, n[7:0]);
      end
    end
  endtask
  // irq line level, looked at 1 ns after the edge so it has settled
  task chk_irq(input e);
    begin
      #1;
      total_checks = total_checks + 1;
      if (irq[13] !== e) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: irq line %b want %b", $time, irq[13], e);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // watcher: read data and popped transmit bytes against oldest note
  always @(posedge i_mclk) begin
    if (rd_d)
      cmp(o_rdata);
    if (pop)
      cmp(txb);
    rd_d <= i_rd;
    cyc = cyc + 1;
    // a hang counts as a failure
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  initial begin
    {i_reset_n, i_addr, i_wdata, i_wr, i_rd, rd_d, ev1} = 17'h0;
    {num_errors, total_checks, cyc} = 0;
    rng = 32'h000174DE;
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd(4'h0, 16'hFF40);
    rd(4'h6, 16'hFF01);
    rd(4'hF, 16'hFF00);
    fill;
    host_u.pkt(1'b1, 4'h8, 1'b0);
    rd(4'h3, 16'hFF01);
    chk_irq(1'b1);
    rd(4'h2, 16'h0101);
    rd(4'h5, 16'hFF08);
    // drain, reading the count after every byte
    for (i = 0; i < 8; i = i + 1) begin
      rd(4'h4, {8'hFF, host_u.pay[i]});
      rd(4'h5, {8'hFF, 8'h07 - i[7:0]});
    end
    wr(4'h3, 8'h40);
    rd(4'h3, 16'hFF00);
    wr(4'h2, 8'h01);
    rd(4'h2, 16'h0100);
    chk_irq(1'b0);
    // other endpoint event while only ep0 may interrupt
    @(posedge i_mclk);
    ev1 <= 1'b1;
    @(posedge i_mclk);
    ev1 <= 1'b0;
    rd(4'h2, 16'h0202);
    chk_irq(1'b0);
    wr(4'h6, 8'h03);
    chk_irq(1'b1);
    wr(4'h6, 8'h01);
    wr(4'h2, 8'h02);
    host_u.in_tx(4'h0);
    // short packet of three bytes
    for (i = 0; i < 3; i = i + 1) begin
      rng = xs(rng);
      tb[i] = rng[7:0];
      wr(4'h4, tb[i]);
    end
    rd(4'h5, 16'hFF03);
    wr(4'h3, 8'h02);
    rd(4'h3, 16'hFF02);
    wr(4'h3, 8'h10);
    rd(4'h3, 16'hFF12);
    for (i = 0; i < 3; i = i + 1)
      expq.push_back({8'hFF, tb[i]});
    host_u.in_tx(4'h3);
    rd(4'h3, 16'h0300);
    rd(4'h2, 16'h0101);
    wr(4'h2, 8'h01);
    host_u.pkt(1'b0, 4'h0, 1'b0);
    rd(4'h3, 16'h0101);
    wr(4'h3, 8'h40);
    // status out while a data packet is still armed
    wr(4'h3, 8'h02);
    host_u.pkt(1'b0, 4'h0, 1'b0);
    rd(4'h3, 16'h2321);
    wr(4'h3, 8'hD0);
    rd(4'h3, 16'hFF10);
    wr(4'h0, 8'h00);
    rd(4'h0, 16'hFF00);
    host_u.det(1'b0);
    rd(4'h1, 16'h0808);
    wr(4'h1, 8'h08);
    rd(4'h1, 16'h0800);
    wr(4'h0, 8'h40);
    rd(4'h0, 16'hFF40);
    host_u.det(1'b1);
    rd(4'h1, 16'h1010);
    wr(4'h0, 8'h44);
    wr(4'h0, 8'h40);
    rd(4'h0, 16'hFF40);
    wr(4'h1, 8'h10);
    rd(4'h1, 16'h1000);
    // suspend again under mask, then clear the suspend state by hand
    host_u.det(1'b0);
    wr(4'h0, 8'h44);
    wr(4'h0, 8'h40);
    host_u.det(1'b1);
    rd(4'h1, 16'h1800);
    // bus reset with a byte left in the fifo
    wr(4'h4, 8'h5A);
    host_u.o_brst <= 1'b1;
    wr(4'h0, 8'h00);
    rd(4'h0, 16'hFF40);
    rd(4'h3, 16'hFF00);
    rd(4'h5, 16'hFF00);
    rd(4'h6, 16'hFF01);
    rd(4'h1, 16'h2020);
    host_u.o_brst <= 1'b0;
    wr(4'h0, 8'h00);
    rd(4'h0, 16'hFF00);
    wr(4'h1, 8'h20);
    rd(4'h1, 16'h2000);
    fill;
    host_u.pkt(1'b1, 4'h8, 1'b1);
    rd(4'h3, 16'h0100);
    repeat (4) @(posedge i_mclk);
    tally_and_finish;
  end
endmodule
